/* File: dv/self_prog_lock_fuse_access_tb_top.sv */
`timescale 1ns/1ps
module self_prog_lock_fuse_access_tb_top;
    localparam int         WCYC  = 20;
    localparam logic [7:0] F_LOW = 8'h6c;
    localparam logic [7:0] F_HI  = 8'hc3;
    localparam logic [1:0] CA    = slfa_pkg::CTRL_ADDR;
    localparam int         LIMIT = 3000;

    typedef struct {
        logic        cmd;
        logic        busy;
        int          gap;
        logic [15:0] z;
        logic [7:0]  exp;
    } slfa_row_t;

    logic                clk               = 1'b0;
    logic                sys_rst           = 1'b1;
    logic                power_on_rst      = 1'b1;
    logic                eeprom_write_busy = 1'b0;
    logic [1:0]          reg_addr;
    logic [7:0]          reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [7:0]          reg_rdata;
    logic                spm_strobe;
    logic                lpm_strobe;
    logic [15:0]         z_ptr;
    logic [7:0]          low_data_reg;
    logic [15:0]         flash_rd_addr;
    logic [7:0]          flash_rd_data;
    logic [7:0]          lpm_data;
    logic                lpm_valid;
    logic [7:0]          lock_bits;
    slfa_pkg::slfa_op_t  flash_op;
    slfa_pkg::slfa_op_t  last_op;
    logic                prog_ready;
    int                  miscompares = 0;
    int                  checks      = 0;
    int                  cycles      = 0;
    logic [7:0]          starts      = 8'h00;
    logic [7:0]          v;
    slfa_row_t           rows [7] = '{
        '{1'b1, 1'b0, 0, 16'h0000, F_LOW},
        '{1'b1, 1'b0, 0, 16'h0003, F_HI},
        '{1'b1, 1'b0, 2, 16'h0001, 8'hff},
        '{1'b1, 1'b0, 1, 16'h0002, F_HI},
        '{1'b1, 1'b0, 4, 16'h0001, 8'h1e},
        '{1'b1, 1'b1, 0, 16'h0000, 8'h0f},
        '{1'b0, 1'b0, 0, 16'h1234, 8'h4b}
    };

    always #10 clk = ~clk;

    slfa_core #(.WRITE_CYCLES(WCYC), .FUSE_LOW(F_LOW), .FUSE_HIGH(F_HI)) dut (
        .clk(clk), .sys_rst(sys_rst), .power_on_rst(power_on_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .spm_strobe(spm_strobe),
        .lpm_strobe(lpm_strobe), .z_ptr(z_ptr), .low_data_reg(low_data_reg),
        .eeprom_write_busy(eeprom_write_busy), .flash_rd_addr(flash_rd_addr),
        .flash_rd_data(flash_rd_data), .lpm_data(lpm_data),
        .lpm_valid(lpm_valid), .lock_bits(lock_bits), .flash_op(flash_op),
        .prog_ready(prog_ready));

    slfa_cpu_model cpu (
        .clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .spm_strobe(spm_strobe),
        .lpm_strobe(lpm_strobe), .z_ptr(z_ptr), .low_data_reg(low_data_reg),
        .flash_rd_addr(flash_rd_addr), .flash_rd_data(flash_rd_data));

    // ------------------------------------------------------------
    // Operation monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (flash_op.start === 1'b1)
        begin
            starts  <= starts + 8'h01;
            last_op <= flash_op;
        end
        if (cycles == LIMIT)
        begin
            miscompares = miscompares + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        checks = checks + 1;
        if (got !== exp)
        begin
            miscompares = miscompares + 1;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    // ------------------------------------------------------------
    // Core instruction helpers
    // ------------------------------------------------------------
    task automatic idle(input int n);
        repeat (n) cpu.cyc(0, 0, 0, 0, 2'h0, 8'h00, 16'h0000, 8'h00);
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        cpu.cyc(1, 0, 0, 0, a, d, 16'h0000, 8'h00);
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        cpu.cyc(0, 1, 0, 0, a, 8'h00, 16'h0000, 8'h00);
        idle(1);
        d = reg_rdata;
    endtask

    task automatic spm(input logic [15:0] z, input logic [7:0] d);
        cpu.cyc(0, 0, 1, 0, 2'h0, 8'h00, z, d);
    endtask

    task automatic lpm(input logic [15:0] z, output logic [7:0] d);
        cpu.cyc(0, 0, 0, 1, 2'h0, 8'h00, z, 8'h00);
        idle(1);
        d = lpm_data;
        chk({7'h00, lpm_valid}, 8'h01, "lpm valid");
    endtask

    task automatic lock_read(input logic [7:0] exp);
        logic [7:0] d;
        wr(CA, 8'h09);
        lpm(16'h0001, d);
        chk(d, exp, "lock byte");
    endtask

    task automatic wait_idle();
        logic [7:0] c;
        int         n;
        c = 8'h01;
        n = 0;
        while (c[0] !== 1'b0 && n < 60)
        begin
            rd(CA, c);
            n = n + 1;
        end
        chk({7'h00, c[0]}, 8'h00, "engine finish");
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        sys_rst      <= 1'b0;
        power_on_rst <= 1'b0;
        rd(CA, v);
        chk(v, slfa_pkg::CTRL_RESET, "ctrl reset");
        $display("test reset done");
        foreach (rows[i])
        begin
            eeprom_write_busy <= rows[i].busy;
            if (rows[i].cmd)
                wr(CA, 8'h09);
            idle(rows[i].gap);
            lpm(rows[i].z, v);
            chk(v, rows[i].exp, "timed read");
            idle(4);
            eeprom_write_busy <= 1'b0;
            rd(CA, v);
            chk(v, 8'h00, "flags after read");
            $display("test row %0d done", i);
        end
        wr(CA, 8'ha0);
        rd(CA, v);
        chk(v, 8'h80, "ctrl layout");
        chk({7'h00, prog_ready}, 8'h01, "ready level");
        wr(2'h2, 8'hff);
        rd(2'h2, v);
        chk(v, 8'h00, "unmapped");
        wr(CA, 8'h00);
        $display("test register done");
        wr(CA, 8'h09);
        idle(3);
        spm(16'hbeef, 8'hd7);
        lpm(16'h0005, v);
        chk(v, 8'h5a, "flash read in lock write");
        chk(starts, 8'h01, "lock op start");
        chk({7'h00, last_op.lock}, 8'h01, "lock op kind");
        idle(6);
        rd(CA, v);
        chk({7'h00, v[0]}, 8'h01, "busy in write");
        wait_idle();
        lock_read(8'hd7);
        chk(lock_bits, 8'hd7, "lock bits port");
        $display("test lock set done");
        wr(CA, 8'h09);
        idle(4);
        spm(16'h0001, 8'hc3);
        idle(2);
        rd(CA, v);
        chk(v, 8'h00, "spm window expiry");
        eeprom_write_busy <= 1'b1;
        wr(CA, 8'h09);
        spm(16'h0001, 8'hc3);
        idle(4);
        eeprom_write_busy <= 1'b0;
        chk(starts, 8'h01, "refused starts");
        lock_read(8'hd7);
        $display("test refusal done");
        wr(CA, 8'h09);
        spm(16'h0001, 8'hfb);
        idle(3);
        sys_rst <= 1'b1;
        idle(1);
        sys_rst <= 1'b0;
        wait_idle();
        lock_read(8'hd3);
        $display("test reset in write done");
        wr(CA, 8'h03);
        spm(16'h0140, 8'h00);
        wait_idle();
        rd(CA, v);
        chk(v, 8'h40, "section busy");
        chk(last_op.addr[7:0], 8'h40, "erase addr");
        chk({7'h00, last_op.erase}, 8'h01, "erase kind");
        wr(CA, 8'h11);
        spm(16'h0000, 8'h00);
        idle(1);
        rd(CA, v);
        chk(v, 8'h00, "section re-enabled");
        wr(CA, 8'h05);
        spm(16'h0180, 8'h00);
        wait_idle();
        chk({7'h00, last_op.write}, 8'h01, "write kind");
        power_on_rst <= 1'b1;
        idle(1);
        power_on_rst <= 1'b0;
        lock_read(8'hff);
        $display("test erase and power on done");
        print_verdict();
    end
endmodule

/* File: dv/slfa_cpu_model.sv */
`timescale 1ns/1ps
module slfa_cpu_model (
    input  wire logic        clk,
    output logic      [1:0]  reg_addr,
    output logic      [7:0]  reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             spm_strobe,
    output logic             lpm_strobe,
    output logic      [15:0] z_ptr,
    output logic      [7:0]  low_data_reg,
    input  wire logic [15:0] flash_rd_addr,
    output logic      [7:0]  flash_rd_data
);
    // ------------------------------------------------------------
    // Program memory content, unlike any fuse or lock value used at the addresses the test reads
    // ------------------------------------------------------------
    assign flash_rd_data = {flash_rd_addr[3:0], ~flash_rd_addr[3:0]};

    initial
    begin
        reg_addr     = 2'h0;
        reg_wdata    = 8'h00;
        reg_wr       = 1'b0;
        reg_rd       = 1'b0;
        spm_strobe   = 1'b0;
        lpm_strobe   = 1'b0;
        z_ptr        = 16'h0000;
        low_data_reg = 8'h00;
    end

    // ------------------------------------------------------------
    // One core cycle; unused data lines toggle so stale values fail
    // ------------------------------------------------------------
    task automatic cyc(input logic wr, input logic rd, input logic spm,
                       input logic lpm, input logic [1:0] a,
                       input logic [7:0] wd, input logic [15:0] z,
                       input logic [7:0] d);
        reg_wr       <= wr;
        reg_rd       <= rd;
        spm_strobe   <= spm;
        lpm_strobe   <= lpm;
        reg_addr     <= a;
        z_ptr        <= z;
        reg_wdata    <= wr ? wd : ~reg_wdata;
        low_data_reg <= spm ? d : ~low_data_reg;
        @(posedge clk);
    endtask
endmodule

/* File: src/slfa_core.sv */
// The address map and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
module slfa_core #(
    parameter int         WRITE_CYCLES = slfa_pkg::WRITE_CYCLES,
    parameter logic [7:0] FUSE_LOW     = slfa_pkg::FUSE_LOW_DEFAULT,
    parameter logic [7:0] FUSE_HIGH    = slfa_pkg::FUSE_HIGH_DEFAULT
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              power_on_rst,
    input  wire logic [1:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [7:0]        reg_rdata,
    input  wire logic              spm_strobe,
    input  wire logic              lpm_strobe,
    input  wire logic [15:0]       z_ptr,
    input  wire logic [7:0]        low_data_reg,
    input  wire logic              eeprom_write_busy,
    output logic      [15:0]       flash_rd_addr,
    input  wire logic [7:0]        flash_rd_data,
    output logic      [7:0]        lpm_data,
    output logic                   lpm_valid,
    output logic      [7:0]        lock_bits,
    output slfa_pkg::slfa_op_t     flash_op,
    output logic                   prog_ready
);
    if (WRITE_CYCLES < 2 || WRITE_CYCLES >= (1 << slfa_pkg::TIMER_W))
    begin
        $error("WRITE_CYCLES out of range");
    end

    localparam logic [slfa_pkg::TIMER_W-1:0] TIMER_LOAD =
        WRITE_CYCLES[slfa_pkg::TIMER_W-1:0];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    slfa_pkg::slfa_ctrl_t          ctrl;
    slfa_pkg::slfa_ctrl_t          next_ctrl;
    logic [2:0]                    win;
    logic [2:0]                    next_win;
    logic                          busy_flag;
    logic                          next_busy_flag;
    logic [7:0]                    rdata;
    logic [7:0]                    next_rdata;
    logic [7:0]                    next_lpm_data;
    logic                          next_lpm_valid;
    slfa_pkg::slfa_op_t            next_flash_op;
    slfa_pkg::slfa_state_t         state;
    slfa_pkg::slfa_state_t         next_state;
    logic [slfa_pkg::TIMER_W-1:0]  timer;
    logic [slfa_pkg::TIMER_W-1:0]  next_timer;
    logic [3:0]                    pend;
    logic [3:0]                    next_pend;
    logic                          pend_lock;
    logic                          next_pend_lock;
    logic [7:0]                    next_lock_bits;
    logic                          ctrl_wr;
    logic                          in_spm_win;
    logic                          in_lpm_win;
    logic                          spm_ok;
    logic                          lpm_ok;
    logic                          spm_prog;

    assign flash_rd_addr = z_ptr;
    assign reg_rdata     = rdata;
    assign prog_ready    = ctrl.irq_en && (state == slfa_pkg::SLFA_IDLE);
    assign ctrl_wr       = reg_wr && (reg_addr == slfa_pkg::CTRL_ADDR);
    assign in_spm_win    = (state == slfa_pkg::SLFA_ARMED)
                           && (win < slfa_pkg::SPM_WINDOW);
    assign in_lpm_win    = (state == slfa_pkg::SLFA_ARMED)
                           && (win < slfa_pkg::LPM_WINDOW);
    // EEPROM write blocks every programming command and every fuse read
    assign spm_ok   = spm_strobe && in_spm_win && !eeprom_write_busy;
    assign lpm_ok   = lpm_strobe && in_lpm_win && ctrl.lock_set
                      && !eeprom_write_busy;
    assign spm_prog = spm_ok
                      && (ctrl.lock_set || ctrl.pg_write || ctrl.pg_erase);

    // ------------------------------------------------------------
    // Next values
    // ------------------------------------------------------------
    always_comb
    begin
        next_ctrl      = ctrl;
        next_win       = win;
        next_busy_flag = busy_flag;
        next_state     = state;
        next_timer     = timer;
        next_pend      = pend;
        next_pend_lock = pend_lock;
        next_lock_bits = lock_bits;
        next_flash_op  = '0;
        next_rdata     = 8'h00;
        next_lpm_valid = lpm_strobe;
        next_lpm_data  = flash_rd_data;
        if (lpm_ok)
        begin
            // Pointer bit 1 picks the high fuse byte, else bit 0 picks
            // lock byte or low fuse byte
            if (z_ptr[1] == slfa_pkg::Z_FUSE_HIGH[1])
                next_lpm_data = FUSE_HIGH;
            else if (z_ptr[0] == slfa_pkg::Z_LOCK[0])
                next_lpm_data = lock_bits;
            else
                next_lpm_data = FUSE_LOW;
        end
        if (reg_rd && reg_addr == slfa_pkg::CTRL_ADDR)
        begin
            // Reserved bit 5 reads zero
            next_rdata = {ctrl.irq_en, busy_flag, 1'b0, ctrl.rd_en,
                          ctrl.lock_set, ctrl.pg_write, ctrl.pg_erase,
                          state != slfa_pkg::SLFA_IDLE};
        end
        case (state)
            slfa_pkg::SLFA_IDLE,
            slfa_pkg::SLFA_ARMED:
            begin
                if (state == slfa_pkg::SLFA_ARMED)
                    next_win = win + 3'h1;
                if (ctrl_wr)
                begin
                    next_ctrl = {reg_wdata[slfa_pkg::BIT_IRQ_EN],
                                 reg_wdata[slfa_pkg::BIT_RD_EN],
                                 reg_wdata[slfa_pkg::BIT_LOCK_SET],
                                 reg_wdata[slfa_pkg::BIT_PG_WRITE],
                                 reg_wdata[slfa_pkg::BIT_PG_ERASE]};
                    next_win  = 3'h0;
                    next_state = reg_wdata[slfa_pkg::BIT_ENABLE]
                                 ? slfa_pkg::SLFA_ARMED
                                 : slfa_pkg::SLFA_IDLE;
                end
                else if (spm_prog)
                begin
                    next_state          = slfa_pkg::SLFA_PROG;
                    next_timer          = TIMER_LOAD;
                    next_pend_lock      = ctrl.lock_set;
                    // Lock data from the low data register only
                    next_pend = low_data_reg[slfa_pkg::BOOT_MSB:
                                             slfa_pkg::BOOT_LSB];
                    next_flash_op.start = 1'b1;
                    next_flash_op.lock  = ctrl.lock_set;
                    next_flash_op.erase = ctrl.pg_erase && !ctrl.lock_set;
                    next_flash_op.write = ctrl.pg_write && !ctrl.lock_set;
                    next_flash_op.addr  = z_ptr;
                    // Lock writes never block the flash for reading
                    if (!ctrl.lock_set)
                        next_busy_flag = 1'b1;
                end
                else if (spm_ok || lpm_ok)
                begin
                    // Re-enable or page load clears section busy
                    if (spm_ok)
                        next_busy_flag = 1'b0;
                    next_ctrl  = '{irq_en: ctrl.irq_en, default: 1'b0};
                    next_state = slfa_pkg::SLFA_IDLE;
                end
                else if (state == slfa_pkg::SLFA_ARMED
                         && win == slfa_pkg::SPM_WINDOW - 3'h1)
                begin
                    // Window expiry, also after an EEPROM-blocked command
                    next_ctrl  = '{irq_en: ctrl.irq_en, default: 1'b0};
                    next_state = slfa_pkg::SLFA_IDLE;
                end
            end
            slfa_pkg::SLFA_PROG:
            begin
                next_timer = timer - 1'b1;
                if (ctrl_wr)
                    next_ctrl.irq_en = reg_wdata[slfa_pkg::BIT_IRQ_EN];
                if (timer == 1)
                begin
                    if (pend_lock)
                    begin
                        // Zero in the data programs the matching lock bit
                        next_lock_bits[slfa_pkg::BOOT_MSB:
                                       slfa_pkg::BOOT_LSB] =
                            lock_bits[slfa_pkg::BOOT_MSB:
                                      slfa_pkg::BOOT_LSB] & pend;
                    end
                    next_ctrl  = '{irq_en: next_ctrl.irq_en, default: 1'b0};
                    next_state = slfa_pkg::SLFA_IDLE;
                end
            end
            default:
            begin
                next_state = slfa_pkg::SLFA_IDLE;
            end
        endcase
        // System reset drops windows but lets a flash write run on
        if (sys_rst && state != slfa_pkg::SLFA_PROG)
            next_state = slfa_pkg::SLFA_IDLE;
    end

    // ------------------------------------------------------------
    // Registers cleared by system reset
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (sys_rst || power_on_rst)
        begin
            ctrl      <= '0;
            win       <= 3'h0;
            busy_flag <= 1'b0;
            rdata     <= 8'h00;
            lpm_data  <= 8'h00;
            lpm_valid <= 1'b0;
            flash_op  <= '0;
        end
        else
        begin
            ctrl      <= next_ctrl;
            win       <= next_win;
            busy_flag <= next_busy_flag;
            rdata     <= next_rdata;
            lpm_data  <= next_lpm_data;
            lpm_valid <= next_lpm_valid;
            flash_op  <= next_flash_op;
        end
    end

    // ------------------------------------------------------------
    // Write engine, survives system reset
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (power_on_rst)
        begin
            state     <= slfa_pkg::SLFA_IDLE;
            timer     <= '0;
            pend      <= 4'hf;
            pend_lock <= 1'b0;
            lock_bits <= slfa_pkg::LOCK_RESET;
        end
        else
        begin
            state     <= next_state;
            timer     <= next_timer;
            pend      <= next_pend;
            pend_lock <= next_pend_lock;
            lock_bits <= next_lock_bits;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || power_on_rst);

    sequence s_arm_lock;
        ctrl_wr && reg_wdata[slfa_pkg::BIT_ENABLE]
        && reg_wdata[slfa_pkg::BIT_LOCK_SET] && state != slfa_pkg::SLFA_PROG;
    endsequence

    sequence s_quiet;
        !ctrl_wr && !spm_strobe && !lpm_strobe;
    endsequence

    a_lock_never_erased: assert property (
        !$past(power_on_rst)
        |-> (lock_bits & ~$past(lock_bits)) == 8'h00)
        else $error("lock bit returned to one");
    a_window_expires: assert property (
        s_arm_lock ##1 s_quiet [*4] |=> state == slfa_pkg::SLFA_IDLE)
        else $error("window did not expire after four cycles");
    a_lock_starts_prog: assert property (
        s_arm_lock ##1 (spm_strobe && !eeprom_write_busy && !ctrl_wr)
        |=> state == slfa_pkg::SLFA_PROG && flash_op.lock)
        else $error("lock-set store not started");
    a_ee_blocks_spm: assert property (
        state == slfa_pkg::SLFA_ARMED && spm_strobe && eeprom_write_busy
        && !ctrl_wr |=> state != slfa_pkg::SLFA_PROG && !flash_op.start)
        else $error("command taken during EEPROM write");
    a_ee_blocks_read: assert property (
        lpm_strobe && eeprom_write_busy
        |=> lpm_valid && lpm_data == $past(flash_rd_data))
        else $error("fuse read during EEPROM write");
    a_plain_read: assert property (
        lpm_strobe && state == slfa_pkg::SLFA_IDLE
        |=> lpm_valid && lpm_data == $past(flash_rd_data))
        else $error("ordinary read wrong");
    a_lock_read: assert property (
        s_arm_lock ##1 (lpm_strobe && !eeprom_write_busy && !ctrl_wr
        && z_ptr == slfa_pkg::Z_LOCK) |=> lpm_data == lock_bits
        && state == slfa_pkg::SLFA_IDLE)
        else $error("lock byte read wrong");
    a_fuse_low_read: assert property (
        s_arm_lock ##1 (lpm_strobe && !eeprom_write_busy && !ctrl_wr
        && z_ptr == slfa_pkg::Z_FUSE_LOW) |=> lpm_data == FUSE_LOW)
        else $error("low fuse read wrong");
    a_lock_no_block: assert property (
        flash_op.start && flash_op.lock |-> busy_flag == $past(busy_flag))
        else $error("lock write blocked the flash");
    a_timer_counts: assert property (
        state == slfa_pkg::SLFA_PROG && timer > 1
        |=> state == slfa_pkg::SLFA_PROG && timer == $past(timer) - 1'b1)
        else $error("write timer not counting");
    a_reserved_zero: assert property (
        $past(reg_rd) |-> !reg_rdata[5])
        else $error("reserved bit not zero");
endmodule

/* File: src/slfa_pkg.sv */
package slfa_pkg;
    // ------------------------------------------------------------
    // Register map and control bit positions
    // ------------------------------------------------------------
    localparam logic [1:0] CTRL_ADDR    = 2'h0;
    localparam int         BIT_IRQ_EN   = 7;
    localparam int         BIT_BUSY     = 6;
    localparam int         BIT_RD_EN    = 4;
    localparam int         BIT_LOCK_SET = 3;
    localparam int         BIT_PG_WRITE = 2;
    localparam int         BIT_PG_ERASE = 1;
    localparam int         BIT_ENABLE   = 0;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    // ------------------------------------------------------------
    // Timed windows, counted from the cycle of the register write
    // ------------------------------------------------------------
    localparam logic [2:0] SPM_WINDOW   = 3'h4;
    localparam logic [2:0] LPM_WINDOW   = 3'h3;
    // ------------------------------------------------------------
    // Flash write time
    // ------------------------------------------------------------
    localparam int WRITE_MIN_US  = 3700;
    localparam int WRITE_MAX_US  = 4500;
    localparam int CLK_PERIOD_NS = 20;
    localparam int WRITE_CYCLES  =
        (WRITE_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W       = 20;
    // ------------------------------------------------------------
    // Lock and fuse layout, read selection by pointer bits
    // ------------------------------------------------------------
    localparam logic [15:0] Z_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] Z_LOCK      = 16'h0001;
    localparam logic [15:0] Z_FUSE_HIGH = 16'h0003;
    localparam int          BOOT_LSB    = 2;
    localparam int          BOOT_MSB    = 5;
    localparam logic [7:0]  LOCK_RESET  = 8'hff;
    localparam logic [7:0]  FUSE_LOW_DEFAULT  = 8'hff;
    localparam logic [7:0]  FUSE_HIGH_DEFAULT = 8'hff;

    typedef enum logic [1:0] {
        SLFA_IDLE  = 2'b00,
        SLFA_ARMED = 2'b01,
        SLFA_PROG  = 2'b11
    } slfa_state_t;

    typedef struct packed {
        logic irq_en;
        logic rd_en;
        logic lock_set;
        logic pg_write;
        logic pg_erase;
    } slfa_ctrl_t;

    typedef struct packed {
        logic        start;
        logic        erase;
        logic        write;
        logic        lock;
        logic [15:0] addr;
    } slfa_op_t;
endpackage
